// ===== rtl/hbm_mapper.sv
// hbm_mapper: picks the e1 bit times that carry hdlc data, rx and tx
`timescale 1ns/10ps
`default_nettype none
module hbm_mapper
    import hbm_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 8
) (
    input  wire logic              aclk,             // 25 mhz clock
    input  wire logic              aresetn,          // sync reset, low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,     // write address
    input  wire logic              s_axi_awvalid,    // write addr valid
    output logic                   s_axi_awready,    // write addr ready
    input  wire logic [31:0]       s_axi_wdata,      // write data
    input  wire logic [3:0]        s_axi_wstrb,      // byte enables
    input  wire logic              s_axi_wvalid,     // write data valid
    output logic                   s_axi_wready,     // write data ready
    output logic [1:0]             s_axi_bresp,      // write response
    output logic                   s_axi_bvalid,     // write resp valid
    input  wire logic              s_axi_bready,     // write resp ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,     // read address
    input  wire logic              s_axi_arvalid,    // read addr valid
    output logic                   s_axi_arready,    // read addr ready
    output logic [31:0]            s_axi_rdata,      // read data
    output logic [1:0]             s_axi_rresp,      // read response
    output logic                   s_axi_rvalid,     // read data valid
    input  wire logic              s_axi_rready,     // read data ready
    input  wire logic [7:0]        hdlc_tx_data,     // byte from hdlc
    input  wire logic              hdlc_tx_valid,    // byte offered
    output logic                   hdlc_tx_ready,    // fifo has room
    input  wire logic              tx_bit_strobe,    // one tx bit time
    input  wire logic [4:0]        tx_slot,          // tx time slot
    input  wire logic [3:0]        tx_bitnum,        // tx ds0 bit 1..8
    input  wire logic              tx_nfas,          // tx non-fas frame
    input  wire logic              tx_line_data_in,  // normal tx bit
    output logic                   tx_line_data_out, // bit to line
    output logic                   tx_hdlc_used,     // last bit was hdlc
    input  wire logic              rx_bit_strobe,    // one rx bit time
    input  wire logic [4:0]        rx_slot,          // rx time slot
    input  wire logic [3:0]        rx_bitnum,        // rx ds0 bit 1..8
    input  wire logic              rx_nfas,          // rx non-fas frame
    input  wire logic              rx_line_data,     // received bit
    output logic                   rx_hdlc_bit,      // bit for receiver
    output logic                   rx_hdlc_bit_valid // pulse with bit
);

    typedef struct packed {
        logic [7:0]  rx_route;
        logic [7:0]  rx_mask;
        logic [7:0]  tx_route;
        logic [7:0]  tx_mask;
        logic [4:0]  rx_sa;
        logic [31:0] tx_blk;
        logic [31:0] rx_blk;
        hbm_bus_st_t wst;
        hbm_bus_st_t rst;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_idx;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wr_err;
        logic [31:0] rdata;
        logic        rd_err;
        logic [7:0]  shift;
        logic [3:0]  left;
        logic        tx_out;
        logic        tx_used;
        logic        rx_bit;
        logic        rx_valid;
    } hbm_st_t;

    hbm_st_t     st;
    hbm_st_t     next_st;
    logic        tx_en;
    logic        tx_hit;
    logic [7:0]  rx_ctl;
    logic [4:0]  rx_sel;
    logic        rx_hit;
    logic [31:0] rd_word;
    logic        rd_bad;
    logic [7:0]  ar_idx;

    hbm_stream_if #(.W(8)) f_in ();
    hbm_stream_if #(.W(8)) f_out ();

    // hdlc bytes wait here; a full fifo stalls the hdlc controller
    hbm_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .aclk    (aclk),
        .aresetn (aresetn),
        .in_s    (f_in),
        .out_s   (f_out)
    );
    assign f_in.data     = hdlc_tx_data;
    assign f_in.valid    = hdlc_tx_valid;
    assign hdlc_tx_ready = f_in.ready;
    // a byte is pulled only once the shifter has sent every bit
    assign f_out.ready   = (st.left == '0);

    // bus handshakes come straight from state
    assign s_axi_awready = (st.wst == BUS_IDLE) && !st.aw_got;
    assign s_axi_wready  = (st.wst == BUS_IDLE) && !st.w_got;
    assign s_axi_bvalid  = (st.wst == BUS_RESP);
    assign s_axi_bresp   = st.wr_err ? RESP_SLVERR : RESP_OKAY;
    assign s_axi_arready = (st.rst == BUS_IDLE);
    assign s_axi_rvalid  = (st.rst == BUS_RESP);
    assign s_axi_rresp   = st.rd_err ? RESP_SLVERR : RESP_OKAY;
    assign s_axi_rdata   = st.rdata;
    assign ar_idx        = s_axi_araddr[IDX_LSB +: IDX_W];

    // data outputs straight from flip-flops
    assign tx_line_data_out  = st.tx_out;
    assign tx_hdlc_used      = st.tx_used;
    assign rx_hdlc_bit       = st.rx_bit;
    assign rx_hdlc_bit_valid = st.rx_valid;

    // bit-time selection for both directions
    always_comb begin
        tx_en  = st.tx_route[F_ENABLE];
        // route bit only counts once the enable is set
        tx_hit = tx_en && hbm_bit_used(st.tx_route,
                     st.tx_route[F_CHAN_HI:0], st.tx_blk,
                     st.tx_mask, tx_slot, tx_bitnum, tx_nfas);
        // source clear forces the sa path with the rx control two select
        rx_ctl = st.rx_route[F_ENABLE] ? st.rx_route : RST_CTRL8;
        rx_sel = st.rx_route[F_ENABLE] ? st.rx_route[F_CHAN_HI:0]
                                       : st.rx_sa;
        rx_hit = hbm_bit_used(rx_ctl, rx_sel, st.rx_blk,
                     st.rx_mask, rx_slot, rx_bitnum, rx_nfas);
    end

    // register read decode
    always_comb begin
        rd_word = '0;
        rd_bad  = 1'b0;
        case (ar_idx)
            IDX_RX_ROUTE: rd_word = 32'(st.rx_route);
            IDX_RX_MASK:  rd_word = 32'(st.rx_mask);
            IDX_TX_ROUTE: rd_word = 32'(st.tx_route);
            IDX_TX_MASK:  rd_word = 32'(st.tx_mask);
            IDX_RX_SA:    rd_word = 32'(st.rx_sa);
            IDX_TX_BLK:   rd_word = st.tx_blk;
            IDX_RX_BLK:   rd_word = st.rx_blk;
            IDX_STATUS: begin
                rd_word[ST_EMPTY] = !f_out.valid;
                rd_word[ST_FULL]  = !f_in.ready;
                rd_word[ST_LEFT_LSB +: 4] = st.left;
            end
            default: rd_bad = 1'b1;
        endcase
    end

    // next state: bus slave, tx shifter, rx tap
    always_comb begin
        next_st = st;
        // address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got = 1'b1;
            next_st.aw_idx = s_axi_awaddr[IDX_LSB +: IDX_W];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        case (st.wst)
            BUS_IDLE: begin
                if (st.aw_got && st.w_got) begin
                    next_st.wst    = BUS_RESP;
                    next_st.aw_got = 1'b0;
                    next_st.w_got  = 1'b0;
                    next_st.wr_err = 1'b0;
                    case (st.aw_idx)
                        IDX_RX_ROUTE: next_st.rx_route = 8'(hbm_merge(
                            32'(st.rx_route), st.wdata, st.wstrb));
                        IDX_RX_MASK:  next_st.rx_mask = 8'(hbm_merge(
                            32'(st.rx_mask), st.wdata, st.wstrb));
                        IDX_TX_ROUTE: next_st.tx_route = 8'(hbm_merge(
                            32'(st.tx_route), st.wdata, st.wstrb));
                        IDX_TX_MASK:  next_st.tx_mask = 8'(hbm_merge(
                            32'(st.tx_mask), st.wdata, st.wstrb));
                        IDX_RX_SA:    next_st.rx_sa = 5'(hbm_merge(
                            32'(st.rx_sa), st.wdata, st.wstrb));
                        IDX_TX_BLK:   next_st.tx_blk = hbm_merge(
                            st.tx_blk, st.wdata, st.wstrb);
                        IDX_RX_BLK:   next_st.rx_blk = hbm_merge(
                            st.rx_blk, st.wdata, st.wstrb);
                        IDX_STATUS:   next_st.wr_err = 1'b0;
                        default:      next_st.wr_err = 1'b1;
                    endcase
                end
            end
            BUS_RESP: begin
                if (s_axi_bready) begin
                    next_st.wst = BUS_IDLE;
                end
            end
            default: next_st.wst = BUS_IDLE;
        endcase
        case (st.rst)
            BUS_IDLE: begin
                if (s_axi_arvalid) begin
                    next_st.rst    = BUS_RESP;
                    next_st.rdata  = rd_word;
                    next_st.rd_err = rd_bad;
                end
            end
            BUS_RESP: begin
                if (s_axi_rready) begin
                    next_st.rst = BUS_IDLE;
                end
            end
            default: next_st.rst = BUS_IDLE;
        endcase
        // reload never meets a shift: reload needs left at zero
        if (f_out.valid && f_out.ready) begin
            next_st.shift = f_out.data;
            next_st.left  = DS0_BITS;
        end
        // hdlc bits go out lsb first; empty shifter sends idle ones
        if (tx_bit_strobe) begin
            next_st.tx_used = tx_hit;
            if (tx_hit) begin
                if (st.left != '0) begin
                    next_st.tx_out = st.shift[0];
                    next_st.shift  = st.shift >> 1;
                    next_st.left   = 4'(st.left - 1'b1);
                end else begin
                    next_st.tx_out = IDLE_BIT;
                end
            end else begin
                next_st.tx_out = tx_line_data_in;
            end
        end
        next_st.rx_valid = rx_bit_strobe && rx_hit;
        if (rx_bit_strobe && rx_hit) begin
            next_st.rx_bit = rx_line_data;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st          <= '0;
            st.rx_route <= RST_CTRL8;
            st.rx_mask  <= RST_CTRL8;
            st.tx_route <= RST_CTRL8;
            st.tx_mask  <= RST_CTRL8;
            st.rx_sa    <= RST_SA;
            st.tx_blk   <= RST_BLK;
            st.rx_blk   <= RST_BLK;
            st.wst      <= BUS_IDLE;
            st.rst      <= BUS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // checks on the mapping
    tx_off_pass_a: assert property (tx_bit_strobe && !tx_en |=>
        tx_line_data_out == $past(tx_line_data_in) && !tx_hdlc_used)
        else $error("tx data changed while hdlc disabled");
    off_hold_a: assert property (tx_bit_strobe && !tx_en &&
        st.left != '0 |=> st.left == $past(st.left))
        else $error("hdlc advanced while disabled");
    insert_bit_a: assert property (tx_bit_strobe && tx_hit &&
        st.left != '0 |=> tx_line_data_out == $past(st.shift[0]) &&
        st.left == 4'($past(st.left) - 1'b1))
        else $error("hdlc bit not inserted");
    sa4_map_a: assert property (tx_bit_strobe && tx_en &&
        !st.tx_route[F_ROUTE] && tx_slot == SA_SLOT && tx_nfas &&
        tx_bitnum == SA_FIRST_BIT && st.tx_route[F_CHAN_HI]
        |=> tx_hdlc_used)
        else $error("sa4 not used for hdlc");
    chan_single_a: assert property (tx_bit_strobe &&
        st.tx_route[F_ROUTE] && !st.tx_route[F_MODE] &&
        tx_slot != st.tx_route[F_CHAN_HI:0] |=> !tx_hdlc_used)
        else $error("wrong ds0 channel used");
    blk_map_a: assert property (tx_bit_strobe &&
        st.tx_route[F_ROUTE] && st.tx_route[F_MODE] &&
        !st.tx_blk[tx_slot] |=> !tx_hdlc_used)
        else $error("unmapped channel used");
    tx_mask_a: assert property (tx_bit_strobe &&
        st.tx_route[F_ROUTE] && tx_bitnum >= DS0_FIRST &&
        tx_bitnum <= DS0_BITS &&
        st.tx_mask[3'(tx_bitnum - DS0_FIRST)] |=> !tx_hdlc_used)
        else $error("suppressed tx bit used");
    rx_mask_a: assert property (rx_bit_strobe &&
        st.rx_route[F_ENABLE] && st.rx_route[F_ROUTE] &&
        rx_bitnum >= DS0_FIRST && rx_bitnum <= DS0_BITS &&
        st.rx_mask[3'(rx_bitnum - DS0_FIRST)] |=> !rx_hdlc_bit_valid)
        else $error("suppressed rx bit delivered");
    rx_sa_src_a: assert property (rx_bit_strobe &&
        !st.rx_route[F_ENABLE] && rx_slot == SA_SLOT && rx_nfas &&
        rx_bitnum == DS0_BITS && st.rx_sa[0] |=> rx_hdlc_bit_valid &&
        rx_hdlc_bit == $past(rx_line_data))
        else $error("rx sa8 not delivered");
endmodule
`default_nettype wire

// ===== rtl/hbm_pkg.sv
// hbm_pkg: register map, field layout and shared decode for the bit mapper
package hbm_pkg;

    // register indices; byte address is index times four
    localparam int unsigned IDX_LSB      = 2;
    localparam int unsigned IDX_W        = 8;
    localparam int unsigned ADDR_W       = IDX_LSB + IDX_W;
    localparam logic [7:0]  IDX_RX_ROUTE = 8'hb8;
    localparam logic [7:0]  IDX_RX_MASK  = 8'hb9;
    localparam logic [7:0]  IDX_TX_ROUTE = 8'hba;
    localparam logic [7:0]  IDX_TX_MASK  = 8'hbb;
    localparam logic [7:0]  IDX_RX_SA    = 8'hbc;
    localparam logic [7:0]  IDX_TX_BLK   = 8'hbd;
    localparam logic [7:0]  IDX_RX_BLK   = 8'hbe;
    localparam logic [7:0]  IDX_STATUS   = 8'hbf;

    // reset values
    localparam logic [7:0]  RST_CTRL8    = 8'h00;
    localparam logic [4:0]  RST_SA       = 5'h00;
    localparam logic [31:0] RST_BLK      = 32'h0000_0000;

    // route control fields (both directions share the layout)
    localparam int unsigned F_ENABLE     = 7;  // tx enable / rx source
    localparam int unsigned F_ROUTE      = 6;  // 0 = sa bits, 1 = ds0
    localparam int unsigned F_MODE       = 5;  // 0 = one channel, 1 = map
    localparam int unsigned F_CHAN_HI    = 4;  // channel number / sa select

    // status fields
    localparam int unsigned ST_EMPTY     = 0;
    localparam int unsigned ST_FULL      = 1;
    localparam int unsigned ST_LEFT_LSB  = 2;

    // frame geometry
    localparam logic [4:0]  SA_SLOT      = 5'h00;
    localparam logic [3:0]  SA_FIRST_BIT = 4'h4;
    localparam logic [3:0]  DS0_FIRST    = 4'h1;
    localparam logic [3:0]  DS0_BITS     = 4'h8;
    localparam logic        IDLE_BIT     = 1'b1;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } hbm_bus_st_t;

    // byte-lane merge of a bus write into an old register value
    function automatic logic [31:0] hbm_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // is this bit time routed to the hdlc controller
    function automatic logic hbm_bit_used(input logic [7:0]  route,
                                          input logic [4:0]  sa_sel,
                                          input logic [31:0] blk,
                                          input logic [7:0]  mask,
                                          input logic [4:0]  slot,
                                          input logic [3:0]  bitnum,
                                          input logic        nfas);
        logic hit;
        hit = 1'b0;
        if (!route[F_ROUTE]) begin
            // sa4 sits in select bit 4 down to sa8 in select bit 0
            if (slot == SA_SLOT && nfas && bitnum >= SA_FIRST_BIT &&
                bitnum <= DS0_BITS) begin
                hit = sa_sel[3'(DS0_BITS - bitnum)];
            end
        end else if (bitnum >= DS0_FIRST && bitnum <= DS0_BITS) begin
            hit = route[F_MODE] ? blk[slot] : (slot == route[F_CHAN_HI:0]);
            // mask bit 7 is ds0 bit 8, mask bit 0 is ds0 bit 1
            hit = hit && !mask[3'(bitnum - DS0_FIRST)];
        end
        return hit;
    endfunction

endpackage

// ===== rtl/hbm_stream_if.sv
// hbm_stream_if: valid/ready word carrier between mapper and its fifo
`timescale 1ns/10ps
`default_nettype none
interface hbm_stream_if #(parameter int unsigned W = 8);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport source (output data, output valid, input ready);
    modport sink   (input data, input valid, output ready);
endinterface
`default_nettype wire

// ===== rtl/hbm_fifo.sv
// hbm_fifo: flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module hbm_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 8
) (
    input  wire logic     aclk,     // system clock
    input  wire logic     aresetn,  // synchronous reset, active low
    hbm_stream_if.sink    in_s,     // filling side
    hbm_stream_if.source  out_s     // draining side
);
    localparam int unsigned PW = (D > 1) ? $clog2(D) : 1;
    localparam int unsigned CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0]       wp;
        logic [PW-1:0]       rp;
        logic [CW-1:0]       cnt;
    } hbm_fifo_st_t;

    hbm_fifo_st_t st;
    hbm_fifo_st_t next_st;
    logic         push;
    logic         pop;

    // honest flags straight from the count
    assign in_s.ready  = (st.cnt != CW'(D));
    assign out_s.valid = (st.cnt != '0);
    assign out_s.data  = st.mem[st.rp];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    // pointers wrap explicitly so any depth works, not only powers of two
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_s.data;
            next_st.wp = (st.wp == PW'(D - 1)) ? '0 : PW'(st.wp + 1'b1);
        end
        if (pop) begin
            next_st.rp = (st.rp == PW'(D - 1)) ? '0 : PW'(st.rp + 1'b1);
        end
        if (push && !pop) begin
            next_st.cnt = CW'(st.cnt + 1'b1);
        end else if (pop && !push) begin
            next_st.cnt = CW'(st.cnt - 1'b1);
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/hbm_framer_model.sv
// hbm_framer_model: e1 bit-time sequencer standing in for the framer
`timescale 1ns/10ps
`default_nettype none
module hbm_framer_model (
    input  wire logic       aclk,    // system clock
    input  wire logic       aresetn, // sync reset, low
    output logic            strobe,  // one bit time
    output logic [4:0]      slot,    // time slot
    output logic [3:0]      bitnum,  // ds0 bit, 8 first
    output logic            nfas,    // non-fas frame
    output logic            tx_bit,  // normal tx data
    output logic            rx_bit   // line data
);
    logic [1:0] div;
    logic [7:0] pat;
    // a bit time every fourth clock leaves slack between bits
    always_ff @(posedge aclk) begin
        div    <= aresetn ? div + 2'h1 : 2'h0;
        strobe <= aresetn && div == 2'h3;
        if (!aresetn) begin
            slot   <= 5'h00;
            bitnum <= 4'h8;
            nfas   <= 1'b0;
            pat    <= 8'h5a;
        end else if (strobe) begin
            pat    <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
            bitnum <= bitnum == 4'h1 ? 4'h8 : bitnum - 4'h1;
            slot   <= bitnum == 4'h1 ? slot + 5'h01 : slot;
            nfas   <= bitnum == 4'h1 && slot == 5'h1f ? !nfas : nfas;
        end
    end
    // data changes each bit time so a stale bit cannot pass unseen
    assign tx_bit = pat[0];
    assign rx_bit = pat[1];
endmodule
`default_nettype wire

// ===== testbench/hdlc_timeslot_bit_mapper_tb_top.sv
// hdlc_timeslot_bit_mapper_tb_top: random config sweep of the bit mapper
`timescale 1ns/10ps
`default_nettype none
module hdlc_timeslot_bit_mapper_tb_top
    import hbm_pkg::*;
;
    localparam int DEPTH = 8;
    logic        aclk = 1'b0, aresetn = 1'b0, bvq = 1'b0, pend = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, hdlc_tx_valid = 1'b0;
    logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    // shadows start at the reset values so the first bit times are judged
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, wdat, d, v;
    logic [31:0] tbk = 32'h0, rbk = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [7:0]  hdlc_tx_data = 8'h00, wix;
    logic [7:0]  trt = 8'h00, tmk = 8'h00, rrt = 8'h00, rmk = 8'h00;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, hdlc_tx_ready, tx_line_data_out, tx_hdlc_used;
    logic        rx_hdlc_bit, rx_hdlc_bit_valid, strobe, nfas, tx_bit, rx_bit;
    logic        et, ed, er, erb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  bitnum;
    logic [4:0]  slot, rsa = 5'h00;
    logic [15:0] seed = 16'h38e3;
    int          n_errors, cmp_count, cyc, cnt;
    bit          q[$];
    logic [7:0]  ix_t[7] = '{IDX_RX_ROUTE, IDX_RX_MASK, IDX_TX_ROUTE,
                             IDX_TX_MASK, IDX_RX_SA, IDX_TX_BLK, IDX_RX_BLK};
    logic [31:0] wm_t[7] = '{32'hff, 32'hff, 32'hff, 32'hff, 32'h1f,
                             32'hffff_ffff, 32'hffff_ffff};

    hbm_framer_model fm_u (.*);
    hbm_mapper #(.FIFO_DEPTH(DEPTH)) dut_u (
        .*,
        .tx_bit_strobe  (strobe),
        .tx_slot        (slot),
        .tx_bitnum      (bitnum),
        .tx_nfas        (nfas),
        .tx_line_data_in(tx_bit),
        .rx_bit_strobe  (strobe),
        .rx_slot        (slot),
        .rx_bitnum      (bitnum),
        .rx_nfas        (nfas),
        .rx_line_data   (rx_bit)
    );

    always #20 aclk = ~aclk;

    function automatic logic [31:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        rnd[15:0] = seed;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        rnd[31:16] = seed;
    endfunction

    // expected routing of one bit time, written from the register layout
    function automatic logic use_f(input logic [7:0] rt, input logic [4:0] sa,
                                   input logic [31:0] bk, input logic [7:0] mk,
                                   input logic [4:0] sl, input logic [3:0] bn);
        if (!rt[6]) return sl == 0 && nfas && bn >= 4 && sa[8 - bn];
        return (rt[5] ? bk[sl] : sl == rt[4:0]) && !mk[bn - 1];
    endfunction

    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // write holds each channel until its own ready, then waits for bvalid
    task automatic wr(input logic [7:0] ix, input logic [31:0] dt);
        @(posedge aclk);
        wix = ix;
        wdat = dt;
        s_axi_awaddr <= {ix, 2'b00};
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ix);
        @(posedge aclk);
        s_axi_araddr <= {ix, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // offer bytes for n cycles; accepted bytes join the expected bit queue
    task automatic push(input int n);
        @(posedge aclk);
        cnt = 0;
        hdlc_tx_data <= 8'(rnd());
        hdlc_tx_valid <= 1'b1;
        repeat (n) begin
            @(posedge aclk);
            if (hdlc_tx_ready) begin
                for (int b = 0; b < 8; b++) q.push_back(hdlc_tx_data[b]);
                cnt++;
                hdlc_tx_data <= 8'(rnd());
            end
        end
        hdlc_tx_valid <= 1'b0;
    endtask

    // shadow registers follow the write commit, then each bit time is judged
    always @(posedge aclk) begin
        if (s_axi_bvalid && !bvq) begin
            case (wix)
                IDX_RX_ROUTE: rrt = wdat[7:0];
                IDX_RX_MASK: rmk = wdat[7:0];
                IDX_TX_ROUTE: trt = wdat[7:0];
                IDX_TX_MASK: tmk = wdat[7:0];
                IDX_RX_SA: rsa = wdat[4:0];
                IDX_TX_BLK: tbk = wdat;
                IDX_RX_BLK: rbk = wdat;
                default: ;
            endcase
        end
        bvq = s_axi_bvalid;
        if (pend) begin
            chk(tx_hdlc_used === et, "tx use");
            chk(tx_line_data_out === ed, "tx bit");
            chk(rx_hdlc_bit_valid === er, "rx use");
            if (er) chk(rx_hdlc_bit === erb, "rx bit");
        end
        pend = strobe && aresetn;
        if (pend) begin
            et = trt[7] && use_f(trt, trt[4:0], tbk, tmk, slot, bitnum);
            ed = !et ? tx_bit : (q.size() > 0 ? q.pop_front() : IDLE_BIT);
            er = use_f(rrt[7] ? rrt : 8'h00, rrt[7] ? rrt[4:0] : rsa,
                       rbk, rmk, slot, bitnum);
            erb = rx_bit;
        end
    end

    // hang guard: the sweep needs about 17k cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            $display("[ERR] %0t timeout", $time);
            wrap_up();
        end
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (ix_t[k]) begin
            rd(ix_t[k]);
            chk(d === 32'h0 && r === RESP_OKAY, "reset value");
        end
        wr(8'h00, 32'hffff_ffff);
        chk(r === RESP_SLVERR, "unmapped write");
        rd(8'h00);
        chk(d === 32'h0 && r === RESP_SLVERR, "unmapped read");
        // tx disabled, so the fifo fills; the shifter holds one more byte
        push(16);
        chk(cnt == DEPTH + 1, "fifo fill count");
        rd(IDX_STATUS);
        chk(d[ST_FULL] === 1'b1 && d[ST_EMPTY] === 1'b0 &&
            d[ST_LEFT_LSB +: 4] === DS0_BITS, "fifo status");
        // every route and mode pairing, rest of each register random
        for (int i = 0; i < 8; i++) begin
            wr(IDX_TX_ROUTE, 32'h0);
            if (i > 0) push(4);
            foreach (ix_t[k]) begin
                v = rnd() & wm_t[k];
                if (ix_t[k] == IDX_TX_ROUTE) v[7:5] = {i != 0, i[0], i[1]};
                if (ix_t[k] == IDX_RX_ROUTE) v[7:5] = {i[2], i[0], i[1]};
                wr(ix_t[k], v);
                rd(ix_t[k]);
                chk(d === v && r === RESP_OKAY, "readback");
            end
            repeat (2100) @(posedge aclk);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
